// *** analog_die_serial_ctrl_status.sv ***
`timescale 1ns/10ps
`include "serial_params.svh"
module analog_die_serial_ctrl_status #(
  parameter int unsigned WD_INIT_CYCLES = `WD_INIT_CYC,
  parameter int unsigned WD_CLOSED_CYCLES = `WD_HALF_CYC,
  parameter int unsigned WD_OPEN_CYCLES = `WD_HALF_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_en,
  input wire logic sys_reset,
  input wire logic select_n,
  input wire logic serial_shift_clock,
  input wire logic mosi,
  output logic miso_out,
  output logic miso_oe,
  input wire logic lin_wake,
  input wire logic lin_fault,
  input wire logic supply_input_over,
  input wire logic supply_input_under,
  input wire logic battery_fail_in,
  input wire logic regulator_hot,
  input wire logic high_side_hot,
  input wire logic [1:0] wake_inputs,
  output logic [1:0] bus_slew_select,
  output logic bus_pullup_cut,
  output logic [2:0] high_side_enables,
  output logic sleep_mode,
  output logic stop_mode,
  output logic lin_tx_enable,
  output logic watchdog_reset
);
  import serial_pkg::*;

  // select and its delayed copy start at idle high, so no false edge follows reset
  localparam state_s RST_STATE = '{
    sy1: 12'h002,
    sy2: 12'h002,
    ss_d: 1'b1,
    first_read: 1'b1,
    lin_tx_on: 1'b1,
    op: OP_RUN,
    wd: WD_INIT,
    default: '0
  };

  state_s q;
  state_s d;
  logic sck_s;
  logic ss_s;
  logic mosi_s;
  logic sck_rise;
  logic sck_fall;
  logic ss_fall;
  logic ss_rise;
  logic commit;
  logic src;
  logic [7:0] status;
  logic lp_cmd;
  logic wd_clr;
  logic [1:0] wk_rise;

  // only second-stage sync outputs are read
  assign sck_s = q.sy2[`I_SCK];
  assign ss_s = q.sy2[`I_SS];
  assign mosi_s = q.sy2[`I_MOSI];
  assign sck_rise = sck_s & ~q.sck_d;
  assign sck_fall = ~sck_s & q.sck_d;
  assign ss_fall = ~ss_s & q.ss_d;
  assign ss_rise = ss_s & ~q.ss_d;
  assign commit = ss_rise && q.cnt == `BYTE_EDGES;
  assign wk_rise = q.sy2[`I_WK] & ~q.wk_d;

  // latched flags take bits 5:3 and 1:0 over while src is set, live levels otherwise; bits 6 and 2 always latched, bit 4 bat_f on first read
  assign src = q.lin_f | q.ov_f | q.uv_f | q.hot_f | q.hs_f | (|q.wake_src);
  assign status[`S_SRC] = src;
  assign status[`S_LIN] = q.lin_f;
  assign status[`S_OV] = src ? q.ov_f : q.sy2[`I_OV];
  assign status[`S_UV] = q.first_read ? q.bat_f : (src ? q.uv_f : q.sy2[`I_UV]);
  assign status[`S_HOT] = src ? q.hot_f : q.sy2[`I_RHOT];
  assign status[`S_HS] = q.hs_f;
  assign status[1:0] = src ? q.wake_src : q.sy2[`I_WK];

  // the exact byte is compared, so noise in either copy blocks entry
  assign lp_cmd = q.rx[`F_SLEW] == `SLEW_LP && q.rx[`F_HS] == 3'h0 && !q.rx[1];
  assign wd_clr = commit && q.rx[`F_MODE] == `MODE_WDCLR && q.op == OP_RUN;

  always_comb begin
    d = q;
    d.sy1 = {wake_inputs, high_side_hot, regulator_hot, battery_fail_in, supply_input_under,
             supply_input_over, lin_fault, lin_wake, mosi, select_n, serial_shift_clock};
    d.sy2 = q.sy1;
    d.sck_d = sck_s;
    d.ss_d = ss_s;
    d.wk_d = q.sy2[`I_WK];
    d.wd_rst = 1'b0;
    if (ss_fall) begin
      d.active = 1'b1;
      d.cnt = 4'h0;
      d.tx = status;
      d.snap = status;
      d.miso = status[7];
      d.miso_oe = 1'b1;
    end
    if (q.active && sck_rise) begin
      d.miso = q.tx[7];
      d.tx = {q.tx[6:0], 1'b0};
    end
    if (q.active && sck_fall) begin
      d.rx = {q.rx[6:0], mosi_s};
      if (q.cnt != `CNT_MAX) begin
        d.cnt = q.cnt + 4'h1;
      end
    end
    if (ss_rise) begin
      d.active = 1'b0;
      d.miso_oe = 1'b0;
    end
    // a short or long transfer falls through here untouched
    if (commit) begin
      d.ctrl = q.rx;
      if (q.hs_f) begin
        d.ctrl[`F_HS] = 3'h0;
      end
      if (q.snap[`S_LIN]) begin
        d.lin_f = 1'b0;
      end
      if (q.snap[`S_HS]) begin
        d.hs_f = 1'b0;
      end
      if (q.snap[`S_SRC]) begin
        if (q.snap[`S_OV]) begin
          d.ov_f = 1'b0;
        end
        if (q.snap[`S_UV] && !q.first_read) begin
          d.uv_f = 1'b0;
        end
        if (q.snap[`S_HOT]) begin
          d.hot_f = 1'b0;
        end
        d.wake_src = 2'h0;
      end
      if (q.first_read) begin
        d.bat_f = 1'b0;
        d.first_read = 1'b0;
      end
      d.prev_cmd = q.rx;
      d.prev_lp = lp_cmd;
      if (lp_cmd && q.prev_lp && q.rx == q.prev_cmd) begin
        d.op = q.rx[0] ? OP_STOP : OP_SLEEP;
        d.prev_lp = 1'b0;
      end else if (q.rx[`F_MODE] == `MODE_RUN) begin
        d.op = OP_RUN;
      end
    end
    // sets come last so a new event beats a clear in the same cycle
    if (q.sy2[`I_LWK] || q.sy2[`I_LFT]) begin
      d.lin_f = 1'b1;
    end
    if (q.sy2[`I_OV]) begin
      d.ov_f = 1'b1;
    end
    if (q.sy2[`I_UV]) begin
      d.uv_f = 1'b1;
    end
    if (q.sy2[`I_BAT]) begin
      d.bat_f = 1'b1;
    end
    if (q.sy2[`I_RHOT]) begin
      d.hot_f = 1'b1;
    end
    if (q.sy2[`I_HHOT]) begin
      d.hs_f = 1'b1;
      d.ctrl[`F_HS] = 3'h0;
    end
    if (q.sy2[`I_LFT]) begin
      d.lin_tx_on = 1'b0;
    end else if (!d.lin_f) begin
      d.lin_tx_on = 1'b1;
    end
    if (q.op != OP_RUN && (q.sy2[`I_LWK] || (|wk_rise))) begin
      d.wake_src = d.wake_src | wk_rise;
      d.op = OP_RUN;
    end
    // watchdog is held while the device sleeps or stops
    if (q.op == OP_RUN) begin
      unique case (q.wd)
        WD_INIT: begin
          if (wd_clr) begin
            d.wd = WD_CLOSED;
            d.wd_cnt = 24'h0;
          end else if (q.wd_cnt == 24'(WD_INIT_CYCLES - 1)) begin
            d.wd_rst = 1'b1;
          end else begin
            d.wd_cnt = q.wd_cnt + 24'h1;
          end
        end
        WD_CLOSED: begin
          if (wd_clr) begin
            d.wd_rst = 1'b1;
          end else if (q.wd_cnt == 24'(WD_CLOSED_CYCLES - 1)) begin
            d.wd = WD_OPEN;
            d.wd_cnt = 24'h0;
          end else begin
            d.wd_cnt = q.wd_cnt + 24'h1;
          end
        end
        WD_OPEN: begin
          if (wd_clr) begin
            d.wd = WD_CLOSED;
            d.wd_cnt = 24'h0;
          end else if (q.wd_cnt == 24'(WD_OPEN_CYCLES - 1)) begin
            d.wd_rst = 1'b1;
          end else begin
            d.wd_cnt = q.wd_cnt + 24'h1;
          end
        end
        default: begin
          d.wd = WD_INIT;
          d.wd_cnt = 24'h0;
        end
      endcase
    end
    if (sys_reset || d.wd_rst) begin
      d.ctrl[`F_SLEW] = 2'h0;
      d.ctrl[`F_HS] = 3'h0;
      d.op = OP_RUN;
      d.wd = WD_INIT;
      d.wd_cnt = 24'h0;
      d.first_read = 1'b1;
      d.prev_lp = 1'b0;
    end
    // mode levels decoded from the next state so the pins leave straight from flops
    d.sleep_on = d.op == OP_SLEEP;
    d.stop_on = d.op == OP_STOP;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= RST_STATE;
    end else if (clock_en) begin
      q <= d;
    end
  end

  assign miso_out = q.miso;
  assign miso_oe = q.miso_oe;
  assign bus_slew_select = q.ctrl[`F_SLEW];
  assign bus_pullup_cut = q.ctrl[`F_PU];
  assign high_side_enables = q.ctrl[`F_HS];
  assign sleep_mode = q.sleep_on;
  assign stop_mode = q.stop_on;
  assign lin_tx_enable = q.lin_tx_on;
  assign watchdog_reset = q.wd_rst;

  sequence s_sel_fall;
    clock_en && ss_fall;
  endsequence

  sequence s_sel_rise;
    clock_en && ss_rise;
  endsequence

  chk_select_drives: assert property (@(posedge clock) disable iff (rst)
    s_sel_fall |=> miso_oe && q.snap == $past(status)) else $error("select fall did not drive or snapshot");
  chk_deselect_hiz: assert property (@(posedge clock) disable iff (rst)
    s_sel_rise |=> !miso_oe) else $error("output still driven after deselect");
  chk_commit_slew: assert property (@(posedge clock) disable iff (rst)
    s_sel_rise ##0 commit && !sys_reset && !d.wd_rst |=> bus_slew_select == $past(q.rx[7:6]))
    else $error("control byte not committed");
  chk_bad_count: assert property (@(posedge clock) disable iff (rst)
    s_sel_rise ##0 !commit && !sys_reset && !q.sy2[`I_HHOT] && !d.wd_rst
      |=> $stable(q.ctrl) && $stable(q.prev_cmd) && $stable(q.prev_lp) && $stable(q.first_read))
    else $error("bad transfer changed control");
  chk_edge_count: assert property (@(posedge clock) disable iff (rst)
    clock_en && q.active && sck_fall && q.cnt < 4'h8 |=> q.cnt == $past(q.cnt) + 4'h1)
    else $error("sample edge not counted");
  chk_sys_reset: assert property (@(posedge clock) disable iff (rst)
    clock_en && sys_reset |=> bus_slew_select == 2'h0 && high_side_enables == 3'h0 && $stable(bus_pullup_cut))
    else $error("system reset clear wrong");
  chk_hs_thermal: assert property (@(posedge clock) disable iff (rst)
    clock_en && q.sy2[`I_HHOT] |=> high_side_enables == 3'h0 && status[`S_HS])
    else $error("high sides not off on thermal");
  chk_single_lp: assert property (@(posedge clock) disable iff (rst)
    clock_en && commit && q.op == OP_RUN && !q.prev_lp && !sys_reset |=> q.op == OP_RUN)
    else $error("low power entered on one command");
  chk_wd_closed: assert property (@(posedge clock) disable iff (rst)
    clock_en && q.wd == WD_CLOSED && wd_clr |=> watchdog_reset ##1 !watchdog_reset)
    else $error("closed window clear did not reset");
  chk_lin_clear: assert property (@(posedge clock) disable iff (rst)
    clock_en && commit && q.snap[`S_LIN] && !q.sy2[`I_LWK] && !q.sy2[`I_LFT] |=> !q.lin_f)
    else $error("bus flag not cleared by read");

  sequence s_commit;
    clock_en && commit && !sys_reset && !d.wd_rst;
  endsequence

  chk_lp_pair: assert property (@(posedge clock) disable iff (rst)
    s_commit ##0 q.op == OP_RUN && lp_cmd && q.prev_lp && q.rx == q.prev_cmd |=> sleep_mode != stop_mode)
    else $error("repeated low power command ignored");
  chk_hs_restore: assert property (@(posedge clock) disable iff (rst)
    s_commit ##0 q.hs_f |=> high_side_enables == 3'h0)
    else $error("high sides back without a fresh write");
  chk_tx_blocked: assert property (@(posedge clock) disable iff (rst)
    clock_en && q.sy2[`I_LFT] |=> !lin_tx_enable && status[`S_LIN])
    else $error("transmitter not blocked on bus fault");
  chk_wake_run: assert property (@(posedge clock) disable iff (rst)
    clock_en && q.op != OP_RUN && q.sy2[`I_LWK] |=> !sleep_mode && !stop_mode)
    else $error("bus wake did not return to run");
  chk_wd_timeout: assert property (@(posedge clock) disable iff (rst)
    clock_en && q.op == OP_RUN && q.wd == WD_OPEN && !wd_clr && q.wd_cnt == 24'(WD_OPEN_CYCLES - 1)
      |=> watchdog_reset) else $error("open window expiry did not reset");
endmodule

// *** serial_params.svh ***
`ifndef SERIAL_PARAMS_SVH
`define SERIAL_PARAMS_SVH
`define CLK_HZ 10000000
`define BYTE_EDGES 4'h8
`define CNT_MAX 4'hF
`define CTRL_RST 8'h00
`define F_SLEW 7:6
`define F_PU 5
`define F_HS 4:2
`define F_MODE 1:0
`define SLEW_LP 2'h3
`define MODE_SLEEP 2'h0
`define MODE_STOP 2'h1
`define MODE_WDCLR 2'h2
`define MODE_RUN 2'h3
`define S_SRC 7
`define S_LIN 6
`define S_OV 5
`define S_UV 4
`define S_HOT 3
`define S_HS 2
`define N_IN 12
`define I_SCK 0
`define I_SS 1
`define I_MOSI 2
`define I_LWK 3
`define I_LFT 4
`define I_OV 5
`define I_UV 6
`define I_BAT 7
`define I_RHOT 8
`define I_HHOT 9
`define I_WK 11:10
`define WD_INIT_MS 150
`define WD_WIN_MS 150
`define WD_INIT_CYC (`WD_INIT_MS * (`CLK_HZ / 1000))
`define WD_HALF_CYC (`WD_WIN_MS * (`CLK_HZ / 1000) / 2)
`endif

// *** serial_pkg.sv ***
package serial_pkg;
  typedef enum logic [1:0] {OP_RUN, OP_SLEEP, OP_STOP} op_e;
  typedef enum logic [1:0] {WD_INIT, WD_CLOSED, WD_OPEN} wd_e;
  typedef struct packed {
    logic [11:0] sy1;
    logic [11:0] sy2;
    logic sck_d;
    logic ss_d;
    logic [1:0] wk_d;
    logic [7:0] ctrl;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [7:0] snap;
    logic [3:0] cnt;
    logic active;
    logic miso;
    logic miso_oe;
    logic [7:0] prev_cmd;
    logic prev_lp;
    logic lin_f;
    logic ov_f;
    logic uv_f;
    logic bat_f;
    logic hot_f;
    logic hs_f;
    logic [1:0] wake_src;
    logic lin_tx_on;
    logic sleep_on;
    logic stop_on;
    logic first_read;
    op_e op;
    wd_e wd;
    logic [23:0] wd_cnt;
    logic wd_rst;
  } state_s;
endpackage

// *** spi_master_model.sv ***
`timescale 1ns/10ps
module spi_master_model (
  output logic select_n,
  output logic serial_shift_clock,
  output logic mosi,
  input wire logic miso_out,
  input wire logic miso_oe
);
  logic last;
  // a released line never repeats its last bit, so stale data cannot pass
  wire miso_line = miso_oe ? miso_out : ~last;
  initial begin
    select_n = 1'h1;
    serial_shift_clock = 1'h0;
    mosi = 1'h0;
    last = 1'h0;
  end
  // clock stands low outside frames; n other than 8 only for refusal tests
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    logic [7:0] sh;
    sh = tx;
    rx = 8'h00;
    #37;
    select_n = 1'h0;
    #400;
    for (int i = 0; i < n; i++) begin
      serial_shift_clock = 1'h1;
      mosi = sh[7];
      sh = {sh[6:0], 1'h0};
      #400;
      serial_shift_clock = 1'h0;
      rx = {rx[6:0], miso_line};
      last = miso_line;
      #400;
    end
    select_n = 1'h1;
    mosi = ~mosi;
    #800;
  endtask
endmodule

// *** tb_analog_die_serial_ctrl_status.sv ***
`timescale 1ns/10ps
module tb_analog_die_serial_ctrl_status;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic sys_reset = 1'h0;
  logic lin_wake = 1'h0;
  logic lin_fault = 1'h0;
  logic ov = 1'h0;
  logic uv = 1'h0;
  logic bat = 1'h1;
  logic rhot = 1'h0;
  logic hhot = 1'h0;
  logic [1:0] wk = 2'h2;
  logic [7:0] st;
  logic [1:0] slew;
  logic [2:0] hs;
  logic select_n, serial_shift_clock, mosi, miso_out, miso_oe, pu, sleep, stop, tx_en, wd_rst;
  int n_errors = 0;
  int checked = 0;
  int n_wd = 0;
  wire [8:0] outs = {tx_en, slew, pu, hs, stop, sleep};
  always #50 clock = ~clock;
  always @(posedge clock) begin
    if (wd_rst === 1'h1) n_wd++;
  end
  spi_master_model m (.select_n(select_n), .serial_shift_clock(serial_shift_clock), .mosi(mosi),
    .miso_out(miso_out), .miso_oe(miso_oe));
  // short watchdog counts keep the run brief
  analog_die_serial_ctrl_status #(.WD_INIT_CYCLES(4000), .WD_CLOSED_CYCLES(200), .WD_OPEN_CYCLES(400)) DUT (
    .clock(clock), .rst(rst), .clock_en(1'h1), .sys_reset(sys_reset), .select_n(select_n),
    .serial_shift_clock(serial_shift_clock), .mosi(mosi), .miso_out(miso_out), .miso_oe(miso_oe),
    .lin_wake(lin_wake), .lin_fault(lin_fault), .supply_input_over(ov), .supply_input_under(uv),
    .battery_fail_in(bat), .regulator_hot(rhot), .high_side_hot(hhot), .wake_inputs(wk),
    .bus_slew_select(slew), .bus_pullup_cut(pu), .high_side_enables(hs), .sleep_mode(sleep),
    .stop_mode(stop), .lin_tx_enable(tx_en), .watchdog_reset(wd_rst));
  task automatic finish_test;
    if (n_errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] tx, input int n = 8);
    m.xfer(tx, n, st);
    check("idle oe", {8'h00, miso_oe}, 9'h000);
  endtask
  initial begin
    tick(5);
    rst = 1'h0;
    tick(4);
    bat = 1'h0;
    check("reset", outs, 9'h100);
    wr(8'hB7);
    check("first status", {1'h0, st}, 9'h012);
    check("control", outs, 9'h1B4);
    wr(8'hFF, 7);
    wr(8'hFF, 9);
    check("refused", outs, 9'h1B4);
    for (int i = 0; i < 3; i++) begin
      wr({i[1:0], 1'h0, i[2:0], 2'h3});
      check("live status", {1'h0, st}, 9'h002);
      check("slew hs", outs, {1'h1, i[1:0], 1'h0, i[2:0], 2'h0});
    end
    {ov, uv, rhot} = 3'h7;
    tick(4);
    {ov, uv, rhot} = 3'h0;
    tick(4);
    wr(8'h03);
    check("flags", {1'h0, st}, 9'h0B8);
    wr(8'h03);
    check("flags clear", {1'h0, st}, 9'h002);
    wr(8'h1F);
    hhot = 1'h1;
    tick(4);
    hhot = 1'h0;
    tick(4);
    check("hs off", outs, 9'h100);
    wr(8'h1F);
    check("hs flag", {1'h0, st}, 9'h084);
    check("hs held", outs, 9'h100);
    wr(8'h1F);
    check("hs back", outs, 9'h11C);
    lin_fault = 1'h1;
    tick(6);
    check("tx off", outs, 9'h01C);
    lin_fault = 1'h0;
    tick(6);
    check("tx held", outs, 9'h01C);
    wr(8'h1F);
    check("bus flag", {1'h0, st}, 9'h0C0);
    wr(8'h1F);
    check("bus clear", {1'h0, st}, 9'h002);
    check("tx on", outs, 9'h11C);
    // a different byte between the two commands must break the pair
    wr(8'hE0);
    wr(8'h03);
    wr(8'hE0);
    check("pair broken", outs, 9'h1E0);
    wr(8'hE0);
    check("sleep", outs, 9'h1E1);
    wk = 2'h3;
    tick(6);
    check("woken", outs, 9'h1E0);
    wr(8'h03);
    check("wake source", {1'h0, st}, 9'h081);
    wr(8'hC1);
    wr(8'hC1);
    check("stop", outs, 9'h1C2);
    lin_wake = 1'h1;
    tick(4);
    lin_wake = 1'h0;
    tick(6);
    check("bus wake", outs, 9'h1C0);
    wr(8'h77);
    check("wake flag", {1'h0, st}, 9'h0C0);
    check("pullup", outs, 9'h174);
    sys_reset = 1'h1;
    tick(1);
    sys_reset = 1'h0;
    tick(2);
    check("sys reset", outs, 9'h120);
    wr(8'h22);
    wr(8'h22);
    check("closed clear", 9'(n_wd), 9'h001);
    wr(8'h22);
    tick(250);
    wr(8'h22);
    check("open clear", 9'(n_wd), 9'h001);
    tick(700);
    check("open timeout", 9'(n_wd), 9'h002);
    finish_test();
  end
  // a hang ends here instead of running forever
  initial begin
    #1000000;
    n_errors++;
    finish_test();
  end
endmodule
